// File: core/sleep_mode_controller.sv
// sleep_mode_controller.sv: sleep mode control register, clock gating and
// wake-up sequencing for the 8-bit core
// assumes: core, interrupt system and same-domain wake sources share clk_sys; wake
// inputs from pins and async logic are synchronised here
// What the document requires
// RQ1: sleep happens only with enable bit set and a sleep instruction.
// RQ2: mode codes idle 000, noise 001, pdown 010, psave 011, standby 110.
// RQ3: after interrupt wake, core halts four cycles beyond start-up time.
// RQ4: register file and memory stay intact through sleep and wake.
// RQ5: reset during sleep wakes device and restarts at reset vector.
// RQ6: control register bits 7..4 always read zero.
// RQ7: software sets enable just before sleeping and clears after waking.
// RQ8: idle stops only core and flash clocks; others keep running.
// RQ9: in idle any enabled interrupt wakes the device.
// RQ10: entering idle or noise mode starts a conversion if enabled.
// RQ11: noise mode stops io, core, flash clocks; converter, async run.
// RQ12: noise mode wakes only from its listed sources.
// RQ13: power-down stops all generated clocks and main oscillator.
// RQ14: power-down wakes only from resets, watchdog, address match, levels; the code also wakes on pin change.
// RQ15: power-down wake waits the fuse-selected clock restart period.
// RQ16: level wake sources hold their level long enough to be seen.
// RQ17: power-save is power-down with timer 2, async clock, oscillator.
// RQ18: power-save timer 2 wakes only with its enable and global enable.
// RQ19: power-save stops timer oscillator or main clock per timer 2 mode.
// RQ20: standby needs crystal option; keeps oscillator; wakes in six cycles.
// RQ21: in deeper modes external pins wake only via level interrupts; the code also wakes on pin change.
// RQ22: sleep with enable clear or reserved code acts as no-operation.
//
// Added by the designer: the placing of the registers and the plain strobed port.
module sleep_mode_controller
  import sleep_ctrl_pkg::*;
#(
  parameter int RESTART_CYCLES = `SLP_RESTART_DEFAULT,
  parameter int CNT_W          = 16
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // core side
  input  wire logic       sleep_instr,
  input  wire logic       global_irq_en,
  input  wire logic       crystal_option,
  input  wire logic       timer2_async,
  input  wire logic       timer2_enabled,
  input  wire logic       converter_enabled,
  input  wire logic       irq_pending_any,
  output logic            core_halt,
  output logic            wake_to_irq,
  output logic            wake_to_reset,
  output logic            conversion_start,
  // wake sources from async logic and pins
  input  wire logic       ext_reset_wake,
  input  wire logic       watchdog_reset,
  input  wire logic       watchdog_irq,
  input  wire logic       brownout_reset,
  input  wire logic       address_match_irq,
  input  wire logic       level_irq_zero,
  input  wire logic       level_irq_one,
  input  wire logic       edge_irq_zero,
  input  wire logic       edge_irq_one,
  input  wire logic       pin_change_irq,
  // same-domain wake sources
  input  wire logic       conversion_done_irq,
  input  wire logic       timer2_irq,
  input  wire logic       timer2_irq_mask,
  input  wire logic       store_ready_irq,
  // clock domain and oscillator enables
  output logic            core_clock_domain,
  output logic            flash_clock_domain,
  output logic            io_clock_domain,
  output logic            converter_clock_domain,
  output logic            async_clock_domain,
  output logic            main_osc_en,
  output logic            timer_osc_en
);

  localparam int NSYNC = 10;
  localparam logic [7:0] CTRL_RST = `SLP_CTRL_RESET;
  localparam logic [CNT_W-1:0] HALT_CNT =
    CNT_W'(`SLP_HALT_CYCLES);
  localparam logic [CNT_W-1:0] STANDBY_CNT =
    CNT_W'(`SLP_STANDBY_CYCLES);
  localparam logic [CNT_W-1:0] RESTART_CNT = CNT_W'(RESTART_CYCLES);

  sleep_state_t state_reg;
  sleep_state_t state_next;
  logic         sleep_en_reg;
  sleep_mode_t  mode_field_reg;
  sleep_mode_t  active_mode_reg;
  logic         reset_wake_reg;
  logic [7:0]   reg_rdata_reg;
  logic [NSYNC-1:0] sync_a_reg;
  logic [NSYNC-1:0] sync_b_reg;
  logic [NSYNC-1:0] async_in;
  logic         mode_valid;
  logic         enter_sleep;
  logic         reset_src;
  logic         wake_any;
  logic         cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic         cnt_done;
  logic         deep_mode;

  // pin and async-logic inputs, two flops before use
  assign async_in = {ext_reset_wake, watchdog_reset, watchdog_irq,
                     brownout_reset, address_match_irq, level_irq_zero,
                     level_irq_one, edge_irq_zero, edge_irq_one,
                     pin_change_irq};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end else begin
      sync_a_reg <= async_in;
      sync_b_reg <= sync_a_reg;
    end
  end

  // names for the synchronised copies
  logic s_ext_rst, s_wdt_rst, s_wdt_irq, s_bod, s_addr;
  logic s_lvl0, s_lvl1, s_edge0, s_edge1, s_pcint;
  assign {s_ext_rst, s_wdt_rst, s_wdt_irq, s_bod, s_addr,
          s_lvl0, s_lvl1, s_edge0, s_edge1, s_pcint} = sync_b_reg;

  // reserved codes never enter sleep; standby needs a crystal option
  always_comb begin
    case (mode_field_reg)
      `SLP_MODE_IDLE, `SLP_MODE_NOISE,
      `SLP_MODE_PDOWN, `SLP_MODE_PSAVE: mode_valid = 1'b1; // [RQ2]
      `SLP_MODE_STANDBY: mode_valid = crystal_option; // [RQ20]
      default: mode_valid = 1'b0; // [RQ22]
    endcase
  end

  assign enter_sleep = (state_reg == ST_RUN) && sleep_instr &&
                       sleep_en_reg && mode_valid; // [RQ1] [RQ22]

  // control register: software write steers mode and enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleep_en_reg   <= CTRL_RST[`SLP_EN_BIT];
      mode_field_reg <= CTRL_RST[`SLP_MODE_MSB:`SLP_MODE_LSB];
    end else if (reg_wr && reg_addr == `SLP_ADDR_CONTROL) begin
      sleep_en_reg   <= reg_wdata[`SLP_EN_BIT];
      mode_field_reg <= reg_wdata[`SLP_MODE_MSB:`SLP_MODE_LSB];
    end
  end

  // read data valid the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `SLP_ADDR_CONTROL) begin
        reg_rdata_reg <= {4'h0, mode_field_reg, sleep_en_reg}; // [RQ6]
      end else if (reg_addr == `SLP_ADDR_STATUS) begin
        reg_rdata_reg <= {active_mode_reg, state_reg};
      end else begin
        reg_rdata_reg <= 8'h00;
      end
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_reg;

  // resets always wake and send the core to the reset vector
  assign reset_src = s_ext_rst | s_wdt_rst | s_bod; // [RQ5]

  // wake source filter per mode
  always_comb begin
    case (active_mode_reg)
      `SLP_MODE_IDLE:
        wake_any = irq_pending_any | reset_src | s_wdt_irq | s_addr |
                   s_lvl0 | s_lvl1 | s_edge0 | s_edge1 | s_pcint |
                   timer2_irq | conversion_done_irq |
                   store_ready_irq; // [RQ9]
      `SLP_MODE_NOISE:
        wake_any = conversion_done_irq | reset_src | s_wdt_irq |
                   s_addr | timer2_irq | store_ready_irq |
                   s_lvl0 | s_lvl1 | s_pcint; // [RQ12] [RQ21]
      `SLP_MODE_PSAVE:
        wake_any = reset_src | s_wdt_irq | s_addr | s_lvl0 | s_lvl1 |
                   s_pcint | (timer2_irq && timer2_irq_mask &&
                   global_irq_en); // [RQ18] [RQ21]
      default:
        wake_any = reset_src | s_wdt_irq | s_addr | s_lvl0 | s_lvl1 |
                   s_pcint; // [RQ14] [RQ21]
    endcase
  end

  // power-down, and power-save with timer 2 async, take the restart period
  assign deep_mode = (active_mode_reg == `SLP_MODE_PDOWN) ||
                     (active_mode_reg == `SLP_MODE_PSAVE &&
                      timer2_async);

  // restart delay chosen by mode, then a fixed halt before resuming
  always_comb begin
    cnt_load  = 1'b0;
    cnt_value = '0;
    if (state_reg == ST_SLEEP && wake_any) begin
      cnt_load = 1'b1;
      if (deep_mode) begin
        cnt_value = RESTART_CNT; // [RQ15]
      end else if (active_mode_reg == `SLP_MODE_STANDBY) begin
        cnt_value = STANDBY_CNT; // [RQ20]
      end else begin
        cnt_value = CNT_W'(1);
      end
    end else if (state_reg == ST_RESTART && cnt_done) begin
      cnt_load  = 1'b1;
      cnt_value = HALT_CNT; // [RQ3]
    end
  end

  wake_delay_counter #(
    .CNT_W      (CNT_W)
  ) u_delay (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (cnt_load),
    .load_value (cnt_value),
    .done       (cnt_done)
  );

  // sequence: run, sleep, clock restart, halt, resume
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:     if (enter_sleep) state_next = ST_SLEEP;
      ST_SLEEP:   if (wake_any) state_next = ST_RESTART;
      ST_RESTART: if (cnt_done) state_next = ST_HALT;
      ST_HALT:    if (cnt_done) state_next = ST_RESUME; // [RQ3]
      ST_RESUME:  state_next = ST_RUN;
      default:    state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // latch the mode at entry so mid-sleep writes cannot change gating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_mode_reg <= `SLP_MODE_IDLE;
    end else if (enter_sleep) begin
      active_mode_reg <= mode_field_reg; // [RQ1]
    end
  end

  // remember whether a reset caused the wake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_wake_reg <= 1'b0;
    end else if (state_reg == ST_SLEEP && wake_any) begin
      reset_wake_reg <= reset_src; // [RQ5]
    end else if (state_reg == ST_RUN) begin
      reset_wake_reg <= 1'b0;
    end
  end

  // resume pulses: interrupt routine or reset vector
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_to_irq   <= 1'b0;
      wake_to_reset <= 1'b0;
    end else begin
      wake_to_irq   <= state_next == ST_RESUME && !reset_wake_reg; // [RQ3]
      wake_to_reset <= state_next == ST_RESUME && reset_wake_reg; // [RQ5]
    end
  end

  // converter auto-start on entry into idle or noise mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conversion_start <= 1'b0;
    end else begin
      conversion_start <= enter_sleep && converter_enabled &&
        (mode_field_reg == `SLP_MODE_IDLE ||
         mode_field_reg == `SLP_MODE_NOISE); // [RQ10]
    end
  end

  // core halted from entry until resume; state is held, never cleared
  assign core_halt = (state_reg != ST_RUN); // [RQ4]

  // clock gating per mode while asleep; everything runs otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_clock_domain      <= 1'b1;
      flash_clock_domain     <= 1'b1;
      io_clock_domain        <= 1'b1;
      converter_clock_domain <= 1'b1;
      async_clock_domain     <= 1'b1;
      main_osc_en            <= 1'b1;
      timer_osc_en           <= 1'b1;
    end else if (state_next == ST_SLEEP) begin
      core_clock_domain  <= 1'b0; // [RQ8]
      flash_clock_domain <= 1'b0;
      case (enter_sleep ? mode_field_reg : active_mode_reg)
        `SLP_MODE_IDLE: begin
          io_clock_domain        <= 1'b1; // [RQ8]
          converter_clock_domain <= 1'b1;
          async_clock_domain     <= 1'b1;
          main_osc_en            <= 1'b1;
          timer_osc_en           <= timer2_async;
        end
        `SLP_MODE_NOISE: begin
          io_clock_domain        <= 1'b0; // [RQ11]
          converter_clock_domain <= 1'b1;
          async_clock_domain     <= 1'b1;
          main_osc_en            <= 1'b1;
          timer_osc_en           <= timer2_async;
        end
        `SLP_MODE_PSAVE: begin
          io_clock_domain        <= 1'b0; // [RQ17]
          converter_clock_domain <= 1'b0;
          async_clock_domain     <= 1'b1;
          // sync timer keeps main clock, async keeps oscillator
          main_osc_en            <= timer2_enabled && !timer2_async;
          timer_osc_en           <= timer2_async; // [RQ19]
        end
        `SLP_MODE_STANDBY: begin
          io_clock_domain        <= 1'b0;
          converter_clock_domain <= 1'b0;
          async_clock_domain     <= 1'b0;
          main_osc_en            <= 1'b1; // [RQ20]
          timer_osc_en           <= 1'b0;
        end
        default: begin
          io_clock_domain        <= 1'b0; // [RQ13]
          converter_clock_domain <= 1'b0;
          async_clock_domain     <= 1'b0;
          main_osc_en            <= 1'b0;
          timer_osc_en           <= 1'b0;
        end
      endcase
    end else begin
      // restart: oscillators and all domains back on together once sleep ends
      main_osc_en            <= 1'b1;
      timer_osc_en           <= 1'b1;
      io_clock_domain        <= 1'b1;
      converter_clock_domain <= 1'b1;
      async_clock_domain     <= 1'b1;
      core_clock_domain      <= 1'b1;
      flash_clock_domain     <= 1'b1;
    end
  end

endmodule : sleep_mode_controller

// File: core/sleep_ctrl_map.svh
// sleep_ctrl_map.svh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from the package only; design files use its macros through it
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH

`define SLP_ADDR_CONTROL    4'h0
`define SLP_ADDR_STATUS     4'h1
`define SLP_ADDR_W          4
`define SLP_CTRL_RESET      8'h00
`define SLP_EN_BIT          0
`define SLP_MODE_LSB        1
`define SLP_MODE_MSB        3
`define SLP_MODE_IDLE       3'h0
`define SLP_MODE_NOISE      3'h1
`define SLP_MODE_PDOWN      3'h2
`define SLP_MODE_PSAVE      3'h3
`define SLP_MODE_STANDBY    3'h6
`define SLP_HALT_CYCLES     4
`define SLP_STANDBY_CYCLES  6
`define SLP_RESTART_DEFAULT 16

`endif

// File: core/sleep_ctrl_pkg.sv
// sleep_ctrl_pkg.sv: types shared by the sleep controller files
// assumes: sleep_ctrl_map.svh is on the include path
`include "sleep_ctrl_map.svh"

package sleep_ctrl_pkg;

  // controller sequence states, one-hot
  typedef enum logic [4:0] {
    ST_RUN     = 5'b00001,
    ST_SLEEP   = 5'b00010,
    ST_RESTART = 5'b00100,
    ST_HALT    = 5'b01000,
    ST_RESUME  = 5'b10000
  } sleep_state_t;

  typedef logic [2:0] sleep_mode_t;

endpackage : sleep_ctrl_pkg

// File: core/wake_delay_counter.sv
// wake_delay_counter.sv: loadable down-counter timing the wake-up delays
// assumes: same clock domain as the sleep controller, load and count
// never asked for in the same cycle by the caller
module wake_delay_counter #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_value,
  output logic                  done
);

  logic [CNT_W-1:0] count_reg;

  // load wins over counting; stops at zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - CNT_W'(1);
    end
  end

  // done reads the count only: the caller's load is decoded from done,
  // so folding load back in here would close a combinational loop
  assign done = (count_reg == '0);

endmodule : wake_delay_counter

// File: tb/sleep_wake_model.sv
// sleep_wake_model.sv: far-side wake sources, each one a held level
// assumes: clk_sys domain; the bench picks a source and asks it to rise
module sleep_wake_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       raise,
  input  wire logic [3:0] sel,
  input  wire logic       woken,
  output logic     [13:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // a level stays up until the core resumes, so the two-flop
  // synchronisers cannot miss it; dropping early would be a lost wake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lines <= 14'h0000;
    end else if (woken) begin
      lines <= 14'h0000;
    end else if (raise) begin
      lines[sel] <= 1'b1;
    end
  end
endmodule : sleep_wake_model

// File: tb/sleep_mode_controller_checker.sv
// sleep_mode_controller_checker.sv: port checks of the sleep controller
// assumes: bound to the controller, single clk_sys domain
module sleep_mode_controller_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_instr,
  input wire logic       converter_enabled,
  input wire logic       core_halt,
  input wire logic       wake_to_irq,
  input wire logic       wake_to_reset,
  input wire logic       conversion_start,
  input wire logic       core_clock_domain,
  input wire logic       flash_clock_domain,
  input wire logic       io_clock_domain,
  input wire logic       converter_clock_domain,
  input wire logic       async_clock_domain,
  input wire logic       main_osc_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // entry and exit steps of a sleep
  sequence s_enter;
    $rose(core_halt);
  endsequence
  sequence s_resume;
    wake_to_irq || wake_to_reset;
  endsequence
  a_read_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_upper_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_enter_gated: assert property (
    s_enter |-> $past(sleep_instr) && !core_clock_domain)
    else $error("halt without sleep instruction or core clock on");
  a_core_flash: assert property (
    core_clock_domain == flash_clock_domain)
    else $error("core and flash clocks differ");
  a_io_deps: assert property (
    io_clock_domain |-> converter_clock_domain && main_osc_en)
    else $error("io clock on with converter clock or oscillator off");
  a_conv_deps: assert property (
    converter_clock_domain |-> async_clock_domain && main_osc_en)
    else $error("converter clock on in a stopped mode");
  a_gate_halted: assert property (
    !core_clock_domain |-> core_halt)
    else $error("core clock stopped while not halted");
  a_halt_four: assert property (
    wake_to_irq |-> $past(core_halt, 4) && $past(core_clock_domain, 3))
    else $error("resume without four running halt cycles");
  a_resume_once: assert property (
    s_resume |=> !core_halt && !wake_to_irq && !wake_to_reset)
    else $error("resume pulse not single or halt held");
  a_conv_cause: assert property (
    conversion_start |-> $past(sleep_instr) && $past(converter_enabled))
    else $error("conversion start without cause");
  c_enter: cover property (s_enter);
endmodule : sleep_mode_controller_checker

bind sleep_mode_controller sleep_mode_controller_checker u_chk (
  .clk_sys, .rst, .reg_addr, .reg_rd, .reg_rdata, .sleep_instr,
  .converter_enabled, .core_halt, .wake_to_irq, .wake_to_reset,
  .conversion_start, .core_clock_domain, .flash_clock_domain,
  .io_clock_domain, .converter_clock_domain, .async_clock_domain,
  .main_osc_en
);

// File: tb/sleep_mode_controller_test.sv
// sleep_mode_controller_test.sv: self-checking bench of the sleep controller
// assumes: wake model on the far side; queues hold expected results
module sleep_mode_controller_test;
  import sleep_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 12;
  localparam logic [7:0] REFUSED [5] = '{8'h04, 8'h09, 8'h0B, 8'h0F, 8'h0D};
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic sleep_instr = 1'b0, global_irq_en = 1'b1, crystal_option = 1'b0;
  logic timer2_async = 1'b0, timer2_enabled = 1'b0, t2_mask = 1'b0;
  logic converter_enabled = 1'b1, raise = 1'b0, rd_d = 1'b0, halt_p;
  logic [3:0] sel = 4'h0;
  logic [13:0] lines;
  logic core_halt, wake_to_irq, wake_to_reset, conversion_start;
  logic core_c, flash_c, io_c, conv_c, async_c, main_osc_en, timer_osc_en;
  logic [13:0] exp_clk[$];
  logic [7:0] exp_rd[$];
  logic [1:0] exp_wake[$];
  int num_errors = 0, comparisons = 0, conv_n = 0, seed = 72889;
  wire [6:0] clk_v = {core_c, flash_c, io_c, conv_c, async_c, main_osc_en,
                      timer_osc_en};
  always #20 clk_sys = ~clk_sys;
  sleep_mode_controller #(.RESTART_CYCLES(RC), .CNT_W(16)) dut (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sleep_instr, .global_irq_en, .crystal_option, .timer2_async,
    .timer2_enabled, .converter_enabled, .irq_pending_any(lines[13]),
    .core_halt, .wake_to_irq, .wake_to_reset, .conversion_start,
    .ext_reset_wake(lines[0]), .watchdog_reset(lines[1]),
    .watchdog_irq(lines[2]), .brownout_reset(lines[3]),
    .address_match_irq(lines[4]), .level_irq_zero(lines[5]),
    .level_irq_one(lines[6]), .edge_irq_zero(lines[7]),
    .edge_irq_one(lines[8]), .pin_change_irq(lines[9]),
    .conversion_done_irq(lines[10]), .timer2_irq(lines[11]),
    .timer2_irq_mask(t2_mask), .store_ready_irq(lines[12]),
    .core_clock_domain(core_c), .flash_clock_domain(flash_c),
    .io_clock_domain(io_c), .converter_clock_domain(conv_c),
    .async_clock_domain(async_c), .main_osc_en, .timer_osc_en);
  sleep_wake_model u_far (.clk_sys, .rst, .raise, .sel,
    .woken(wake_to_irq | wake_to_reset), .lines);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    exp_rd.push_back(e);
    @(posedge clk_sys) reg_rd <= 1'b0;
  endtask : rd
  task automatic up(input int s);
    @(posedge clk_sys) {raise, sel} <= {1'b1, 4'(s)};
    @(posedge clk_sys) raise <= 1'b0;
  endtask : up
  task automatic slp();
    @(posedge clk_sys) sleep_instr <= 1'b1;
    @(posedge clk_sys) sleep_instr <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : slp
  // one full sleep: enter, refused wake if pre given, real wake, resume
  task automatic nap(input logic [2:0] m, input logic [13:0] ek,
                     input int pre, input int s, input logic r, input int lat);
    int n;
    wr(4'h0, {4'h0, m, 1'b1});
    exp_clk.push_back(ek);
    slp();
    if (pre >= 0) begin
      up(pre);
      repeat (12) @(posedge clk_sys);
      #1 chk("halt_hold", 8'h01, {7'h00, core_halt});
    end
    t2_mask <= 1'b1;
    exp_wake.push_back({r, ~r});
    up(s);
    n = 0;
    while (!(wake_to_irq | wake_to_reset) && n < 400) begin
      @(negedge clk_sys) n++;
    end
    if (n >= 400) begin
      num_errors++;
      print_verdict();
    end
    if (n < lat) chk("latency", 8'(lat), 8'(n));
    @(negedge clk_sys) chk("halt_off", 8'h00, {7'h00, core_halt});
    rd(4'h0, {4'h0, m, 1'b1});
    wr(4'h0, 8'h00);
    t2_mask <= 1'b0;
    $display("test sleep mode %h done", m);
  endtask : nap
  // result watcher: read data, clocks and wakes take the oldest note; conversion starts are counted
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) chk("rdata", exp_rd.pop_front(), reg_rdata);
    if (core_halt === 1'b1 && halt_p === 1'b0) begin
      chk("clocks", {1'b0, exp_clk[0][6:0]},
          {1'b0, clk_v & exp_clk[0][13:7]});
      void'(exp_clk.pop_front());
    end
    if (wake_to_irq | wake_to_reset)
      chk("wake", 8'(exp_wake.pop_front()),
          {6'h00, wake_to_reset, wake_to_irq});
    if (conversion_start === 1'b1) conv_n++;
    halt_p = core_halt;
  end
  initial begin
    int k;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h01);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h0F);
    wr(4'hF, 8'h5A);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'h00);
    $display("test registers done");
    // refused sleeps: enable clear, reserved codes, standby sans crystal
    for (k = 0; k < 5; k++) begin
      wr(4'h0, REFUSED[k]);
      slp();
      @(negedge clk_sys);
      chk("no_sleep", 8'h01, {7'h00, core_c});
    end
    wr(4'h0, 8'h00);
    $display("test refused sleep done");
    nap(3'h0, {7'h7E, 7'h1E}, -1, 13, 1'b0, 1);
    nap(3'h1, {7'h7E, 7'h0E}, 7, 10, 1'b0, 1);
    converter_enabled <= 1'b0;
    nap(3'h2, {7'h7F, 7'h00}, 7, 5, 1'b0, RC + 4);
    nap(3'h2, {7'h7F, 7'h00}, -1, 1, 1'b1, RC + 4);
    k = 2 + $unsigned($random(seed)) % 3;
    // source 3 is a brown-out, a reset source, so it goes to the vector
    nap(3'h2, {7'h7F, 7'h00}, 8, k + 2 * (k / 4),
        1'(k == 3), RC + 4);
    {timer2_async, timer2_enabled} <= 2'b11;
    nap(3'h3, {7'h7F, 7'h05}, 11, 11, 1'b0, RC + 4);
    timer2_async <= 1'b0;
    nap(3'h3, {7'h7B, 7'h02}, -1, 11, 1'b0, 1);
    crystal_option <= 1'b1;
    nap(3'h6, {7'h7F, 7'h02}, 7, 9, 1'b0, 10);
    rd(4'h1, 8'hC1);
    repeat (2) @(posedge clk_sys);
    chk("conv_starts", 8'h02, 8'(conv_n));
    print_verdict();
  end
endmodule : sleep_mode_controller_test
